/* test/sbgp_pad_model.sv */
// Board-side pad model: resolves each pad from the port driver and the board.
`timescale 1ns/100ps
`default_nettype none
module sbgp_pad_model (
  input  wire logic                      i_mclk,
  input  wire sbgp_pkg::sbgp_pin_drive_s i_drive,
  input  wire logic [5:0]                i_ext,
  input  wire logic [5:0]                i_ext_en,
  output logic [5:0]                     o_pad
);
  import sbgp_pkg::*;
  // A pad nobody drives has no pull, so it wanders rather than keep its last level.
  logic [5:0] float_reg = 6'h15;
  always @(posedge i_mclk) float_reg <= ~float_reg;
  assign o_pad = i_drive.oe & i_drive.dout | ~i_drive.oe & (i_ext_en & i_ext | ~i_ext_en & float_reg);
endmodule // sbgp_pad_model
`default_nettype wire

/* test/sbgp_port_assertions.sv */
// Checker for the six-bit port, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
module sbgp_port_chk (
  input wire logic                      i_mclk,
  input wire logic                      i_rstn,
  input wire logic                      i_ce,
  input wire sbgp_pkg::sbgp_bus_req_s   i_bus,
  input wire logic [7:0]                o_rdata,
  input wire sbgp_pkg::sbgp_pin_drive_s o_pin,
  input wire logic                      i_led_en,
  input wire logic                      i_net_led_a,
  input wire logic                      i_net_led_b,
  input wire logic                      i_comparator_ref_out_en,
  input wire logic [1:0]                o_ref_select,
  input wire sbgp_pkg::sbgp_pullup_s    o_pullup
);
  import sbgp_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  wire       rd_c = i_ce & i_bus.rd;
  wire       wr_c = i_ce & i_bus.wr;
  wire [7:0] wd   = i_bus.wdata;
  wire [1:0] ad   = i_bus.addr;
  cmp_ref_gate_a: assert property (i_comparator_ref_out_en |-> !o_pin.oe[2]) else $error("pin 2 driven");
  led_over_a: assert property (i_led_en |-> o_pin.dout[1:0] == {i_net_led_b, i_net_led_a})
    else $error("led override lost");
  rdata_idle_a: assert property ($past(i_ce) && !$past(rd_c) |-> o_rdata == 8'h00) else $error("rdata not idle");
  unimpl_zero_a: assert property ($past(rd_c) && $past(ad) != OFS_OUTPUT_LATCH |-> !o_rdata[6])
    else $error("bit 6 not zero");
  latch_read_a: assert property ($past(rd_c) && $past(ad) == OFS_OUTPUT_LATCH && !i_led_en
    |-> o_rdata == {o_pullup.pullup_d, o_pullup.pullup_e, o_pin.dout}) else $error("latch read wrong");
  jpull_wr_a: assert property (wr_c && ad == OFS_PIN_LEVEL |=> {o_pullup.pullup_j, 7'h0} == ($past(wd) & 8'h80))
    else $error("port j pull-up wrong");
  depull_wr_a: assert property (wr_c && ad == OFS_OUTPUT_LATCH
    |=> {o_pullup.pullup_d, o_pullup.pullup_e, 6'h0} == ($past(wd) & 8'hc0)) else $error("pull-ups wrong");
  dir_oe_a: assert property (wr_c && ad == OFS_DIRECTION |=> {2'h0, o_pin.oe | 6'h04} == (~$past(wd) & 8'h3f | 8'h04))
    else $error("enable mismatch");
  ref_sel_a: assert property (wr_c && ad == OFS_ANALOG_CONFIG |=> {2'h0, o_ref_select, 4'h0} == ($past(wd) & 8'h30))
    else $error("ref select wrong");
  cover property (rd_c && ad == OFS_PIN_LEVEL);
  cover property (i_led_en && o_pin.oe[0]);
  cover property (i_comparator_ref_out_en);
endmodule // sbgp_port_chk
bind sbgp_port sbgp_port_chk i_sbgp_port_chk (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce), .i_bus(i_bus),
  .o_rdata(o_rdata), .o_pin(o_pin), .i_led_en(i_led_en), .i_net_led_a(i_net_led_a), .i_net_led_b(i_net_led_b),
  .i_comparator_ref_out_en(i_comparator_ref_out_en), .o_ref_select(o_ref_select), .o_pullup(o_pullup));
`default_nettype wire

/* test/tb_top.sv */
// Register-level testbench for the six-bit port.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import sbgp_pkg::*;
  logic            mclk, rstn, ce, led_en, led_a, led_b, cmp_ref_en, tmr;
  logic [5:0]      ext, ext_en, pad;
  logic [7:0]      rdata;
  logic [4:0]      an_en;
  logic [1:0]      ref_sel;
  sbgp_bus_req_s   bus;
  sbgp_pin_drive_s drv;
  sbgp_pullup_s    pu;
  int              n_fail, tests_run;
  sbgp_port i_sbgp_port (.i_mclk(mclk), .i_rstn(rstn), .i_ce(ce), .i_bus(bus), .o_rdata(rdata), .i_pin(pad),
    .o_pin(drv), .i_led_en(led_en), .i_net_led_a(led_a), .i_net_led_b(led_b), .i_comparator_ref_out_en(cmp_ref_en),
    .o_timer_clock_in(tmr), .o_analog_enable(an_en), .o_ref_select(ref_sel), .o_pullup(pu));
  sbgp_pad_model i_sbgp_pad_model (.i_mclk(mclk), .i_drive(drv), .i_ext(ext), .i_ext_en(ext_en), .o_pad(pad));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk) bus <= '0;
    #1;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge mclk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk) bus <= '0;
    #1 chk("rdata", rdata, e);
  endtask
  task automatic complete_run;
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    #100us n_fail++;
    complete_run;
  end
  initial begin
    {n_fail, tests_run, rstn, bus, led_en, led_a, cmp_ref_en} = '0;
    {ce, led_b, ext, ext_en} = '1;
    repeat (3) @(posedge mclk);
    rstn <= 1;
    repeat (3) @(posedge mclk);
    rd(OFS_PIN_LEVEL, 8'h10);
    rd(OFS_OUTPUT_LATCH, 8'h00);
    rd(OFS_DIRECTION, 8'h3f);
    chk("analog", {3'h0, an_en}, 8'h1f);
    chk("pullup", {5'h0, pu}, 8'h00);
    wr(OFS_DIRECTION, 8'hff);
    rd(OFS_DIRECTION, 8'h3f);
    wr(OFS_ANALOG_CONFIG, 8'hff);
    rd(OFS_ANALOG_CONFIG, 8'h3f);
    chk("refsel", {6'h0, ref_sel}, 8'h03);
    for (int s = 0; s < 16; s++) begin
      wr(OFS_ANALOG_CONFIG, 8'(s));
      chk("analog", {3'h0, an_en}, 8'h1f >> s);
    end
    wr(OFS_PIN_LEVEL, 8'hd5);
    rd(OFS_PIN_LEVEL, 8'hbf);
    rd(OFS_OUTPUT_LATCH, 8'h15);
    chk("pullup", {5'h0, pu}, 8'h04);
    wr(OFS_OUTPUT_LATCH, 8'hc5);
    chk("pullup", {5'h0, pu}, 8'h07);
    @(posedge mclk) ext <= 6'h2a;
    repeat (4) @(posedge mclk);
    rd(OFS_PIN_LEVEL, 8'haa);
    rd(OFS_OUTPUT_LATCH, 8'hc5);
    @(posedge mclk) ce <= 0;
    wr(OFS_OUTPUT_LATCH, 8'h00);
    @(posedge mclk) ce <= 1;
    rd(OFS_OUTPUT_LATCH, 8'hc5);
    chk("pullup", {5'h0, pu}, 8'h07);
    @(posedge mclk) ext_en <= '0;
    wr(OFS_DIRECTION, 8'h00);
    chk("oe", {2'h0, drv.oe}, 8'h3f);
    chk("dout", {2'h0, drv.dout}, 8'h05);
    repeat (3) @(posedge mclk);
    rd(OFS_PIN_LEVEL, 8'h85);
    @(posedge mclk) cmp_ref_en <= 1;
    repeat (4) @(posedge mclk);
    #1 chk("oe", {2'h0, drv.oe}, 8'h3b);
    rd(OFS_PIN_LEVEL, 8'h81);
    @(posedge mclk) cmp_ref_en <= 0;
    wr(OFS_ANALOG_CONFIG, 8'h00);
    rd(OFS_PIN_LEVEL, 8'h80);
    chk("dout", {2'h0, drv.dout & drv.oe}, 8'h05);
    @(posedge mclk) led_en <= 1;
    #1 chk("dout", {2'h0, drv.dout}, 8'h06);
    wr(OFS_DIRECTION, 8'h3f);
    @(posedge mclk) {ext_en, ext} <= {6'h3f, 6'h10};
    repeat (4) @(posedge mclk);
    #1 chk("timer", {7'h0, tmr}, 8'h01);
    @(posedge mclk) ext <= 6'h00;
    repeat (4) @(posedge mclk);
    #1 chk("timer", {7'h0, tmr}, 8'h00);
    @(posedge mclk) rstn <= 0;
    #1 chk("pullup", {5'h0, pu}, 8'h00);
    @(posedge mclk) rstn <= 1;
    repeat (3) @(posedge mclk);
    rd(OFS_OUTPUT_LATCH, 8'h00);
    complete_run;
  end
endmodule // tb_top
`default_nettype wire

/* verilog/sbgp_pkg.sv */
package sbgp_pkg;

  localparam int unsigned ADDR_W = 2;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PIN_N  = 6;
  localparam int unsigned AN_N   = 5;

  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL     = 2'h0;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_LATCH  = 2'h1;
  localparam logic [ADDR_W-1:0] OFS_DIRECTION     = 2'h2;
  localparam logic [ADDR_W-1:0] OFS_ANALOG_CONFIG = 2'h3;

  localparam int unsigned BIT_PULLUP_J = 7;
  localparam int unsigned BIT_PULLUP_D = 7;
  localparam int unsigned BIT_PULLUP_E = 6;
  localparam int unsigned BIT_TIMER_PIN = 4;
  localparam int unsigned BIT_CMP_REF_PIN = 2;
  localparam int unsigned BIT_LED_A_PIN = 0;
  localparam int unsigned BIT_LED_B_PIN = 1;
  localparam int unsigned REF_SEL_LSB   = 4;
  localparam int unsigned REF_SEL_W     = 2;
  localparam int unsigned PIN_SEL_W     = 4;

  localparam logic [PIN_N-1:0]     RST_DIRECTION = 6'h3f;
  localparam logic [PIN_N-1:0]     RST_LATCH     = 6'h00;
  localparam logic [REF_SEL_W-1:0] RST_REF_SEL   = 2'h0;
  localparam logic [PIN_SEL_W-1:0] RST_PIN_SEL   = 4'h0;
  localparam logic [DATA_W-1:0]    ZERO_DATA     = 8'h00;

  // Converter channel k sits on pin AN_PIN[k]: channels 0..3 on pins 0..3, channel 4 on pin 5.
  localparam logic [PIN_N-1:0] AN_PIN_MAP [AN_N] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h20};

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } sbgp_bus_req_s;

  typedef struct packed {
    logic [PIN_N-1:0] dout;
    logic [PIN_N-1:0] oe;
  } sbgp_pin_drive_s;

  typedef struct packed {
    logic pullup_j;
    logic pullup_d;
    logic pullup_e;
  } sbgp_pullup_s;

endpackage

/* verilog/sbgp_port.sv */
// Six-bit general-purpose port with analog pin select, LED overrides and pull-up controls.
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module sbgp_port (
  input  wire logic                        i_mclk,
  input  wire logic                        i_rstn,
  input  wire logic                        i_ce,
  input  wire sbgp_pkg::sbgp_bus_req_s     i_bus,
  output logic [sbgp_pkg::DATA_W-1:0]      o_rdata,
  input  wire logic [sbgp_pkg::PIN_N-1:0]  i_pin,
  output sbgp_pkg::sbgp_pin_drive_s        o_pin,
  input  wire logic                        i_led_en,
  input  wire logic                        i_net_led_a,
  input  wire logic                        i_net_led_b,
  input  wire logic                        i_comparator_ref_out_en,
  output logic                             o_timer_clock_in,
  output logic [sbgp_pkg::AN_N-1:0]        o_analog_enable,
  output logic [sbgp_pkg::REF_SEL_W-1:0]   o_ref_select,
  output sbgp_pkg::sbgp_pullup_s           o_pullup
);
  import sbgp_pkg::*;

  // Analog channel mask from the pin-select field: value 0 makes all five
  // channels analog, each step up frees one more, 5 and above is all digital.
  function automatic logic [AN_N-1:0] an_mask(input logic [PIN_SEL_W-1:0] sel);
    logic [AN_N-1:0] m;
    m = '0;
    for (int k = 0; k < AN_N; k++) begin
      m[k] = (32'(sel) + 32'(k)) < 32'(AN_N);
    end
    return m;
  endfunction

  // Spread a channel mask onto pin positions.
  function automatic logic [PIN_N-1:0] an_to_pins(input logic [AN_N-1:0] m);
    logic [PIN_N-1:0] p;
    p = '0;
    for (int k = 0; k < AN_N; k++) begin
      if (m[k]) begin
        p = p | AN_PIN_MAP[k];
      end
    end
    return p;
  endfunction

  // A register slot is written when the write strobe is up and the address matches.
  function automatic logic wr_hit(input sbgp_bus_req_s req, input logic [ADDR_W-1:0] ofs);
    return req.wr && (req.addr == ofs);
  endfunction

  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  logic [PIN_N-1:0]     direction_reg;
  logic [PIN_N-1:0]     output_latch_reg;
  logic [REF_SEL_W-1:0] ref_select_reg;
  logic [PIN_SEL_W-1:0] analog_pin_select_reg;
  sbgp_pullup_s         pullup_reg;
  logic [PIN_N-1:0]     pin_meta_reg;
  logic [PIN_N-1:0]     pin_sync_reg;
  logic [DATA_W-1:0]    rdata_reg;

  logic                 wr_level;
  logic                 wr_latch;
  logic                 wr_dir;
  logic                 wr_cfg;
  logic [PIN_N-1:0]     direction_next;
  logic [PIN_N-1:0]     output_latch_next;
  logic [REF_SEL_W-1:0] ref_select_next;
  logic [PIN_SEL_W-1:0] analog_pin_select_next;
  sbgp_pullup_s         pullup_next;
  logic [DATA_W-1:0]    rdata_next;

  logic [AN_N-1:0]      analog_ch;
  logic [PIN_N-1:0]     analog_pins;
  logic [PIN_N-1:0]     digital_in_en;
  logic [PIN_N-1:0]     pin_level_view;
  logic [PIN_N-1:0]     drive_data;
  logic [PIN_N-1:0]     drive_oe;
  logic                 cmp_ref_on;

  // Register decode.
  assign wr_level = wr_hit(i_bus, OFS_PIN_LEVEL);
  assign wr_latch = wr_hit(i_bus, OFS_OUTPUT_LATCH);
  assign wr_dir   = wr_hit(i_bus, OFS_DIRECTION);
  assign wr_cfg   = wr_hit(i_bus, OFS_ANALOG_CONFIG);

  // A write to either the level or the latch address loads the latch.
  assign output_latch_next = (wr_level || wr_latch) ? i_bus.wdata[PIN_N-1:0] : output_latch_reg;
  assign direction_next    = wr_dir ? i_bus.wdata[PIN_N-1:0] : direction_reg;
  assign ref_select_next   = wr_cfg ? i_bus.wdata[REF_SEL_LSB +: REF_SEL_W] : ref_select_reg;
  assign analog_pin_select_next = wr_cfg ? i_bus.wdata[PIN_SEL_W-1:0] : analog_pin_select_reg;
  assign pullup_next.pullup_j = wr_level ? i_bus.wdata[BIT_PULLUP_J] : pullup_reg.pullup_j;
  assign pullup_next.pullup_d = wr_latch ? i_bus.wdata[BIT_PULLUP_D] : pullup_reg.pullup_d;
  assign pullup_next.pullup_e = wr_latch ? i_bus.wdata[BIT_PULLUP_E] : pullup_reg.pullup_e;

  // Pin input paths.
  assign analog_ch   = an_mask(analog_pin_select_reg);
  assign analog_pins = an_to_pins(analog_ch);
  assign cmp_ref_on  = i_comparator_ref_out_en;
  // Analog pins and a pin 2 carrying the reference output lose their digital input.
  assign digital_in_en = ~analog_pins & ~(PIN_N'(cmp_ref_on) << BIT_CMP_REF_PIN);
  assign pin_level_view = pin_sync_reg & digital_in_en;

  // Output drivers: analog selection has no say here.
  // The LED override changes only the level on pins 0 and 1; the direction
  // bit still owns the enable, so an input pin never shows the LED.
  for (genvar g = 0; g < PIN_N; g++) begin : g_pin_drive
    logic led_pick;
    logic led_level;
    logic ref_block;

    assign led_pick  = i_led_en && ((unsigned'(g) == BIT_LED_A_PIN) || (unsigned'(g) == BIT_LED_B_PIN));
    assign led_level = (unsigned'(g) == BIT_LED_A_PIN) ? i_net_led_a : i_net_led_b;
    assign ref_block = cmp_ref_on && (unsigned'(g) == BIT_CMP_REF_PIN);

    assign drive_data[g] = led_pick ? led_level : output_latch_reg[g];
    assign drive_oe[g]   = !direction_reg[g] && !ref_block;
  end

  // Read mux; unimplemented bits and unknown addresses read as zero.
  always_comb begin
    rdata_next = ZERO_DATA;
    if (i_bus.rd) begin
      case (i_bus.addr)
        OFS_PIN_LEVEL: begin
          rdata_next[PIN_N-1:0]   = pin_level_view;
          rdata_next[BIT_PULLUP_J] = pullup_reg.pullup_j;
        end
        OFS_OUTPUT_LATCH: begin
          rdata_next[PIN_N-1:0]    = output_latch_reg;
          rdata_next[BIT_PULLUP_D] = pullup_reg.pullup_d;
          rdata_next[BIT_PULLUP_E] = pullup_reg.pullup_e;
        end
        OFS_DIRECTION: begin
          rdata_next[PIN_N-1:0] = direction_reg;
        end
        OFS_ANALOG_CONFIG: begin
          rdata_next[REF_SEL_LSB +: REF_SEL_W] = ref_select_reg;
          rdata_next[PIN_SEL_W-1:0]            = analog_pin_select_reg;
        end
        default: begin
          rdata_next = ZERO_DATA;
        end
      endcase
    end
  end

  // Two-stage pin synchroniser; the first stage feeds only the second.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else if (i_ce) begin
      pin_meta_reg <= i_pin;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Control registers come up with every pin an input and pins 5,3:0 analog.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      direction_reg <= RST_DIRECTION;
    end else if (i_ce) begin
      direction_reg <= direction_next;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      output_latch_reg <= RST_LATCH;
    end else if (i_ce) begin
      output_latch_reg <= output_latch_next;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ref_select_reg <= RST_REF_SEL;
    end else if (i_ce) begin
      ref_select_reg <= ref_select_next;
    end
  end

  // A zero select makes pins 5 and 3:0 analog straight out of reset.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      analog_pin_select_reg <= RST_PIN_SEL;
    end else if (i_ce) begin
      analog_pin_select_reg <= analog_pin_select_next;
    end
  end

  // Pull-up enables start cleared on every reset.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pullup_reg <= '0;
    end else if (i_ce) begin
      pullup_reg <= pullup_next;
    end
  end

  // Read data stand for one enabled cycle and fall back to zero at the next one; a low i_ce holds them.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= ZERO_DATA;
    end else if (i_ce) begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata          = rdata_reg;
  assign o_pin            = sbgp_pin_drive_s'{dout: drive_data, oe: drive_oe};
  // Pin 4 reaches the timer whatever its direction bit.
  assign o_timer_clock_in = pin_sync_reg[BIT_TIMER_PIN];
  assign o_analog_enable  = analog_ch;
  assign o_ref_select     = ref_select_reg;
  assign o_pullup         = pullup_reg;

endmodule // sbgp_port
`default_nettype wire
